// [wwt_pkg.sv]
// Constants shared by the watchdog, wake-up and time base block.
`default_nettype none
package wwt_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 2;
    localparam logic [1:0] OFS_STATUS = 2'h0;
    localparam logic [1:0] OFS_INTERRUPT_CONTROL_ONE = 2'h1;
    localparam logic [1:0] OFS_MULTIFUNCTION_INT_CONTROL = 2'h2;
    localparam logic [1:0] OFS_TICK_CONTROL_REGISTER = 2'h3;
    localparam int BIT_TO = 0;
    localparam int BIT_PD = 1;
    localparam int BIT_MF_EN = 0;
    localparam int BIT_MF_REQ = 1;
    localparam int BIT_TB_EN = 0;
    localparam int BIT_TK_EN = 1;
    localparam int BIT_TB_REQ = 2;
    localparam int BIT_TK_REQ = 3;
    localparam int RATE_LSB = 0;
    localparam int RATE_W = 3;
    localparam logic [2:0] RATE_RESET = 3'h0;
    localparam logic [7:0] VECTOR_ADDR = 8'h18;
    localparam int CLK_PERIOD_NS = 8;
    localparam int WAKE_CYCLES = 1024;
    localparam int INT_EXTRA_CYCLES = 4;
    localparam int SYS_DIV = 4;
    localparam int PRE_DIV_BITS = 4;
    localparam int DOG_CNT_BITS = 15;
    localparam int DOG_CHAIN_W = PRE_DIV_BITS + DOG_CNT_BITS;
    localparam int DOG_TAP_BASE = 11;
    localparam int SLOW_CNT_W = 15;
    localparam int TB_TAP_BASE = 11;
    localparam int TICK_TAP_BASE = 7;
    localparam logic [1:0] SRC_RTC = 2'h0;
    localparam logic [1:0] SRC_WDTOSC = 2'h1;
    localparam logic [1:0] SRC_SYS4 = 2'h2;
    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_HALT = 4'h2,
        ST_SETTLE = 4'h4,
        ST_INTWAIT = 4'h8
    } wwt_state_t;
    typedef enum logic [1:0] {
        WK_PLAIN = 2'h0,
        WK_INT = 2'h1,
        WK_DOG = 2'h2
    } wwt_wake_t;
endpackage
`default_nettype wire

// [wwt_ripple_counter.sv]
// Free running binary counter with synchronous clear and advance enable.
`timescale 1ns/100ps
`default_nettype none
module wwt_ripple_counter #(
    parameter int WIDTH = 15
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clear,
    input wire logic advance,
    output logic [WIDTH-1:0] count
);
    // The count restarts from zero on clear, otherwise steps on advance.
    always_ff @(posedge mclk) begin
        if (reset || clear) begin
            count <= '0;
        end else if (advance) begin
            count <= count + 1'b1;
        end
    end
endmodule
`default_nettype wire

// [wwt_core.sv]
// Watchdog, power-down wake-up, time base and periodic tick logic.
// Notes on behaviour
// - Halted dog timeout: flag set, PC/SP reset.
// - Power-down flag: halt sets, clear instruction clears.
// - Enabled Port A falling edge wakes halt.
// - Unserviceable waking interrupt resumes, stays pending.
// - Serviceable waking interrupt takes normal vector.
// - Flag set before halt cannot wake.
// - Every wake waits 1024 system clocks.
// - Interrupt wake adds extra cycles before vector.
// - Dog source divided by 16, counter, final stage.
// - Disabled watchdog makes its instructions no-ops.
// - Clear instruction resets only the final stage.
// - Running timeout pulses device reset, sets flag.
// - Pin low, halt, or running timeout clears count.
// - System-derived dog clock stops while halted.
// - One or two distinct clear instructions clear.
// - Repeated same clear instruction does nothing in two-clear mode.
// - Time base period 2^12 to 2^15.
// - Time base sets flags, calls vector 18H.
// - Tick period 2^8 to 2^15 by rate.
// - Tick sets flags, calls vector 18H.
// - Slow clock source chosen at build time.
// - Dog timeout range chosen among four.
// - Halt sets power-down, clears timeout, stops oscillator.
`timescale 1ns/100ps
`default_nettype none
module wwt_core #(
    parameter bit DOG_ENABLE = 1'b1,
    parameter bit DOG_FROM_SYS4 = 1'b0,
    parameter bit TWO_CLEARS = 1'b0,
    parameter logic [1:0] DOG_RANGE = 2'h0,
    parameter logic [1:0] SLOW_SRC = 2'h0,
    parameter logic [1:0] TB_PERIOD_SEL = 2'h0,
    parameter logic [7:0] PA_WAKE_MASK = 8'hFF
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [wwt_pkg::ADDR_W-1:0] regAddr,
    input wire logic [wwt_pkg::DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [wwt_pkg::DATA_W-1:0] regRdData,
    input wire logic coreHalt,
    input wire logic singleDogClear,
    input wire logic dogClearFirst,
    input wire logic dogClearSecond,
    input wire logic externalResetPin_n,
    input wire logic [7:0] portA,
    input wire logic wdtOscTick,
    input wire logic rtcTick,
    input wire logic stackFull,
    output logic resumeNext,
    output logic vectorCall,
    output logic [7:0] intVector,
    output logic pcSpReset,
    output logic dogReset,
    output logic sysOscRun,
    output logic timeoutFlag,
    output logic powerdownFlag
);
    import wwt_pkg::*;

    localparam logic [1:0] SYS4_LAST = 2'(SYS_DIV - 1);
    localparam logic [9:0] SETTLE_LAST = 10'(WAKE_CYCLES - 1);
    localparam logic [9:0] EXTRA_LAST = 10'(INT_EXTRA_CYCLES - 1);

    wwt_state_t state_q;
    wwt_wake_t wakeKind_q;
    logic [9:0] waitCnt_q;
    logic [1:0] divCnt_q;
    logic [7:0] paPrev_q;
    logic finalStage_q, pendFirst_q, pendSecond_q;
    logic armTb_q, armTk_q;
    logic mfEn_q, mfReq_q, tbEn_q, tkEn_q, tbReq_q, tkReq_q;
    logic [RATE_W-1:0] tickRate_q;
    logic [DOG_CHAIN_W-1:0] dogChain;
    logic [SLOW_CNT_W-1:0] slowCnt;
    logic stRun, stHalt, stSettle, stInt, haltNow, instrOk;
    logic sys4Tick, dogSrcTick, slowTick, dogAdvance, dogCarry;
    logic wdtTimeout, chainClear, clrDone, tbCarry, tickCarry;
    logic portFall, intWake, wake, intReady, vecReady;

    function automatic logic allOnes(input logic [DOG_CHAIN_W-1:0] v,
                                     input int k);
        logic r;
        r = 1'b1;
        for (int i = 0; i < DOG_CHAIN_W; i++) begin
            if (i <= k && !v[i]) begin
                r = 1'b0;
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    assign stRun = (state_q == ST_RUN);
    assign stHalt = (state_q == ST_HALT);
    assign stSettle = (state_q == ST_SETTLE);
    assign stInt = (state_q == ST_INTWAIT);
    assign haltNow = stRun && coreHalt;
    assign instrOk = DOG_ENABLE && stRun;

    assign sys4Tick = (stRun || stInt) && (divCnt_q == SYS4_LAST);
    always_ff @(posedge mclk) begin
        if (reset) begin
            divCnt_q <= 2'h0;
        end else if (stRun || stInt) begin
            divCnt_q <= divCnt_q + 2'h1;
        end
    end

    always_comb begin
        case (SLOW_SRC)
            SRC_RTC: slowTick = rtcTick;
            SRC_WDTOSC: slowTick = wdtOscTick;
            SRC_SYS4: slowTick = sys4Tick;
            default: slowTick = rtcTick;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Dog divider chain.
    assign dogSrcTick = DOG_FROM_SYS4 ? sys4Tick : wdtOscTick;
    assign dogAdvance = DOG_ENABLE && dogSrcTick;
    assign dogCarry = dogAdvance
        && allOnes(dogChain, DOG_TAP_BASE + int'(DOG_RANGE));
    assign wdtTimeout = dogCarry && finalStage_q;
    assign chainClear = !externalResetPin_n || (DOG_ENABLE && haltNow)
        || (wdtTimeout && stRun);

    wwt_ripple_counter #(.WIDTH(DOG_CHAIN_W)) dogCounter (
        .mclk(mclk),
        .reset(reset),
        .clear(chainClear),
        .advance(dogAdvance),
        .count(dogChain)
    );

    assign clrDone = instrOk && (TWO_CLEARS
        ? ((dogClearFirst && pendSecond_q) || (dogClearSecond && pendFirst_q))
        : singleDogClear);

    always_ff @(posedge mclk) begin
        if (reset || clrDone || chainClear) begin
            pendFirst_q <= 1'b0;
            pendSecond_q <= 1'b0;
        end else if (instrOk && TWO_CLEARS) begin
            if (dogClearFirst) begin
                pendFirst_q <= 1'b1;
            end
            if (dogClearSecond) begin
                pendSecond_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || chainClear || clrDone || wdtTimeout) begin
            finalStage_q <= 1'b0;
        end else if (dogCarry) begin
            finalStage_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    wwt_ripple_counter #(.WIDTH(SLOW_CNT_W)) slowCounter (
        .mclk(mclk),
        .reset(reset),
        .clear(1'b0),
        .advance(slowTick),
        .count(slowCnt)
    );

    assign tbCarry = slowTick && allOnes(DOG_CHAIN_W'(slowCnt),
        TB_TAP_BASE + int'(TB_PERIOD_SEL));
    assign tickCarry = slowTick && allOnes(DOG_CHAIN_W'(slowCnt),
        TICK_TAP_BASE + int'(tickRate_q));

    always_ff @(posedge mclk) begin
        if (reset) begin
            tbReq_q <= 1'b0;
        end else if (tbCarry) begin
            tbReq_q <= 1'b1;
        end else if (regWrite && regAddr == OFS_MULTIFUNCTION_INT_CONTROL) begin
            tbReq_q <= regWrData[BIT_TB_REQ];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            tkReq_q <= 1'b0;
        end else if (tickCarry) begin
            tkReq_q <= 1'b1;
        end else if (regWrite && regAddr == OFS_MULTIFUNCTION_INT_CONTROL) begin
            tkReq_q <= regWrData[BIT_TK_REQ];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            mfReq_q <= 1'b0;
        end else if (tbCarry || tickCarry) begin
            mfReq_q <= 1'b1;
        end else if (vecReady) begin
            mfReq_q <= 1'b0;
        end else if (regWrite && regAddr == OFS_INTERRUPT_CONTROL_ONE) begin
            mfReq_q <= regWrData[BIT_MF_REQ];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            mfEn_q <= 1'b0;
            tbEn_q <= 1'b0;
            tkEn_q <= 1'b0;
            tickRate_q <= RATE_RESET;
        end else if (regWrite) begin
            case (regAddr)
                OFS_INTERRUPT_CONTROL_ONE: mfEn_q <= regWrData[BIT_MF_EN];
                OFS_MULTIFUNCTION_INT_CONTROL: begin
                    tbEn_q <= regWrData[BIT_TB_EN];
                    tkEn_q <= regWrData[BIT_TK_EN];
                end
                OFS_TICK_CONTROL_REGISTER: tickRate_q <= regWrData[RATE_LSB +: RATE_W];
                default: tickRate_q <= tickRate_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign intReady = mfEn_q && ((tbEn_q && tbReq_q) || (tkEn_q && tkReq_q));
    assign vecReady = stRun && mfReq_q && intReady && !stackFull
        && !vectorCall;

    always_ff @(posedge mclk) begin
        if (reset) begin
            armTb_q <= 1'b0;
            armTk_q <= 1'b0;
        end else if (haltNow) begin
            armTb_q <= !tbReq_q;
            armTk_q <= !tkReq_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            paPrev_q <= 8'h00;
        end else begin
            paPrev_q <= portA;
        end
    end
    assign portFall = stHalt && |(paPrev_q & ~portA & PA_WAKE_MASK);
    assign intWake = stHalt && ((armTb_q && tbReq_q) || (armTk_q && tkReq_q));
    assign wake = portFall || intWake || (stHalt && wdtTimeout)
        || (stHalt && !externalResetPin_n);

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q <= ST_RUN;
            wakeKind_q <= WK_PLAIN;
            waitCnt_q <= 10'h000;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (coreHalt) begin
                        state_q <= ST_HALT;
                    end
                end
                ST_HALT: begin
                    if (wake) begin
                        state_q <= ST_SETTLE;
                        waitCnt_q <= 10'h000;
                        if (wdtTimeout) begin
                            wakeKind_q <= WK_DOG;
                        end else if (intWake) begin
                            wakeKind_q <= WK_INT;
                        end else begin
                            wakeKind_q <= WK_PLAIN;
                        end
                    end
                end
                ST_SETTLE: begin
                    waitCnt_q <= waitCnt_q + 10'h001;
                    if (waitCnt_q == SETTLE_LAST) begin
                        waitCnt_q <= 10'h000;
                        if (wakeKind_q == WK_INT && intReady && !stackFull) begin
                            state_q <= ST_INTWAIT;
                        end else begin
                            state_q <= ST_RUN;
                        end
                    end
                end
                ST_INTWAIT: begin
                    waitCnt_q <= waitCnt_q + 10'h001;
                    if (waitCnt_q == EXTRA_LAST) begin
                        state_q <= ST_RUN;
                    end
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Resume, PC/SP reset, vector call, dog reset and oscillator outputs.
    always_ff @(posedge mclk) begin
        if (reset) begin
            resumeNext <= 1'b0;
            pcSpReset <= 1'b0;
            vectorCall <= 1'b0;
            intVector <= 8'h00;
            dogReset <= 1'b0;
            sysOscRun <= 1'b1;
        end else begin
            resumeNext <= stSettle && waitCnt_q == SETTLE_LAST
                && wakeKind_q != WK_DOG
                && !(wakeKind_q == WK_INT && intReady && !stackFull);
            pcSpReset <= stSettle && waitCnt_q == SETTLE_LAST
                && wakeKind_q == WK_DOG;
            vectorCall <= vecReady;
            intVector <= vecReady ? VECTOR_ADDR : 8'h00;
            dogReset <= stRun && wdtTimeout;
            sysOscRun <= !(haltNow || (stHalt && !wake));
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            timeoutFlag <= 1'b0;
            powerdownFlag <= 1'b0;
        end else begin
            if (wdtTimeout) begin
                timeoutFlag <= 1'b1;
            end else if (haltNow) begin
                timeoutFlag <= 1'b0;
            end
            if (haltNow) begin
                powerdownFlag <= 1'b1;
            end else if (clrDone) begin
                powerdownFlag <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || !regRead) begin
            regRdData <= 8'h00;
        end else begin
            case (regAddr)
                OFS_STATUS: regRdData <= 8'({powerdownFlag, timeoutFlag});
                OFS_INTERRUPT_CONTROL_ONE: regRdData <= 8'({mfReq_q, mfEn_q});
                OFS_MULTIFUNCTION_INT_CONTROL: regRdData <= 8'({tkReq_q, tbReq_q, tkEn_q, tbEn_q});
                OFS_TICK_CONTROL_REGISTER: regRdData <= 8'(tickRate_q);
                default: regRdData <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    AST_HALT_FLAGS: assert property (
        haltNow |=> powerdownFlag && !timeoutFlag && stHalt && !sysOscRun)
        else $error("Halt did not set power-down state.");
    AST_SETTLE_HOLD: assert property (
        (stHalt && wake) |=> stSettle[*8])
        else $error("Settling ended too early.");
    AST_SETTLE_END: assert property (
        (stSettle && waitCnt_q == SETTLE_LAST) |=> !stSettle)
        else $error("Settling did not end at its count.");
    AST_RUN_TIMEOUT: assert property (
        (stRun && wdtTimeout) |=> dogReset && timeoutFlag)
        else $error("Running timeout did not reset.");
    AST_HALT_TIMEOUT: assert property (
        (stHalt && wdtTimeout) |=> timeoutFlag && powerdownFlag && stSettle)
        else $error("Halted timeout mishandled.");
    AST_PAIR_SAME: assert property (
        (instrOk && TWO_CLEARS && pendFirst_q && dogClearFirst
         && !dogClearSecond && !chainClear) |=> pendFirst_q)
        else $error("Repeated clear changed pairing.");
    AST_FALL_WAKE: assert property (
        portFall |=> stSettle)
        else $error("Port A edge did not wake.");
    AST_NO_STALE: assert property (
        (stHalt && !armTb_q && !armTk_q && !portFall && externalResetPin_n
         && !wdtTimeout) |=> stHalt)
        else $error("Stale flag woke the device.");
    AST_SYS4_STOP: assert property (
        (stHalt || stSettle) |-> !sys4Tick)
        else $error("Instruction clock ran while halted.");
    AST_VECTOR: assert property (
        vectorCall |-> intVector == VECTOR_ADDR && !$past(stackFull)
        && $past(mfEn_q))
        else $error("Vector call without cause.");
    AST_TICK_FLAG: assert property (
        tickCarry |=> tkReq_q && mfReq_q)
        else $error("Tick did not set flags.");

    COV_INT_WAKE: cover property (stInt ##1 stRun);
    COV_DOG_WAKE: cover property (pcSpReset);
    COV_RESUME: cover property (resumeNext);
    COV_PAIR: cover property (TWO_CLEARS && clrDone);
endmodule
`default_nettype wire

// [wwt_core_model.sv]
// Processor core stand-in that issues halt and clear instructions.
`timescale 1ns/100ps
`default_nettype none
module wwt_core_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [1:0] cmd,
    input wire logic keepAlive,
    output logic coreHalt,
    output logic singleDogClear
);
    logic [9:0] gap_q;
    logic [9:0] gap_d;

    assign gap_d = gap_q + 10'h1;

    ////////////////////////////////////////////////////////////////////////
    // Spacing of the keep-alive clears while software runs.
    always_ff @(posedge mclk) begin
        if (reset) begin
            gap_q <= 10'h0;
        end else begin
            gap_q <= gap_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction pulses, one cycle each, launched after the edge.
    always_ff @(posedge mclk) begin
        coreHalt <= !reset && cmd == 2'h1;
        singleDogClear <= !reset && (cmd == 2'h2 ||
            (keepAlive && gap_q == 10'h0));
    end
endmodule
`default_nettype wire

// [test_watchdog_wakeup_timebase.sv]
// Self-checking bench for the watchdog, wake-up and time base block.
`timescale 1ns/100ps
`default_nettype none
module test_watchdog_wakeup_timebase;
    import wwt_pkg::*;
    typedef struct {logic [3:0] code; int lo; int hi;} wwt_note_t;
    logic mclk, reset, regWrite, regRead, rdPend, keepAlive, stackFull;
    logic externalResetPin_n, wdtOscTick, rtcTick, coreHalt, singleDogClear;
    logic [1:0] regAddr, cmd;
    logic [7:0] regWrData, regRdData, portA, intVector;
    logic resumeNext, vectorCall, pcSpReset, dogReset, sysOscRun;
    logic timeoutFlag, powerdownFlag;
    logic clrFirst, clrSecond, pairPd;
    logic [3:0] ev;
    int bad_count, cmp_count, cyc, lastCyc, pin, per, src, i;
    integer seed;
    logic [7:0] rdQ[$];
    wwt_note_t evQ[$];
    wwt_note_t nt;

    wwt_core #(.PA_WAKE_MASK(8'h7F)) dut (.mclk(mclk), .reset(reset),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData), .coreHalt(coreHalt),
        .singleDogClear(singleDogClear), .dogClearFirst(1'b0),
        .dogClearSecond(1'b0), .externalResetPin_n(externalResetPin_n),
        .portA(portA), .wdtOscTick(wdtOscTick), .rtcTick(rtcTick),
        .stackFull(stackFull), .resumeNext(resumeNext),
        .vectorCall(vectorCall), .intVector(intVector),
        .pcSpReset(pcSpReset), .dogReset(dogReset), .sysOscRun(sysOscRun),
        .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag));
    wwt_core_model core (.mclk(mclk), .reset(reset), .cmd(cmd),
        .keepAlive(keepAlive), .coreHalt(coreHalt),
        .singleDogClear(singleDogClear));
    wwt_core #(.PA_WAKE_MASK(8'h7F), .TWO_CLEARS(1'b1),
        .DOG_FROM_SYS4(1'b1)) dutPair (.mclk(mclk), .reset(reset),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(), .coreHalt(coreHalt),
        .singleDogClear(singleDogClear), .dogClearFirst(clrFirst),
        .dogClearSecond(clrSecond), .externalResetPin_n(externalResetPin_n),
        .portA(portA), .wdtOscTick(wdtOscTick), .rtcTick(rtcTick),
        .stackFull(stackFull), .resumeNext(), .vectorCall(), .intVector(),
        .pcSpReset(), .dogReset(), .sysOscRun(), .timeoutFlag(),
        .powerdownFlag(pairPd));
    assign ev = {resumeNext, vectorCall, pcSpReset, dogReset};

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks.
    task automatic check(input string what, input logic [7:0] exp,
            input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        ticks(1);
        regWrite <= 1'b0;
        ticks(1);
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        rdQ.push_back(e);
        regAddr <= a;
        regRead <= 1'b1;
        ticks(1);
        regRead <= 1'b0;
        ticks(1);
    endtask
    task automatic pulse_pair(input logic f, input logic s);
        clrFirst <= f;
        clrSecond <= s;
        ticks(1);
        {clrFirst, clrSecond} <= 2'h0;
        ticks(1);
    endtask
    task automatic instr(input logic [1:0] c);
        cmd <= c;
        ticks(1);
        cmd <= 2'h0;
        ticks(3);
    endtask
    task automatic note(input logic [3:0] c, input int lo, input int hi);
        evQ.push_back('{c, lo, hi});
    endtask
    task automatic settle(input int n);
        int k;
        k = 0;
        while (evQ.size() != 0 && k < n) begin
            ticks(1);
            k++;
        end
        check("event arrival", 8'h0, {7'h0, evQ.size() != 0});
    endtask
    task automatic halt;
        keepAlive <= 1'b0;
        instr(2'h1);
        check("powerdownFlag", 8'h1, powerdownFlag);
        check("timeoutFlag", 8'h0, timeoutFlag);
        check("sysOscRun", 8'h0, sysOscRun);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Result watcher: read data and event pulses against the notes.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (rdPend) begin
            check("regRdData", rdQ.pop_front(), regRdData);
        end
        rdPend <= regRead;
        if (ev !== 4'h0) begin
            lastCyc <= cyc;
            if (evQ.size() == 0) begin
                check("unexpected event", 8'h0, {4'h0, ev});
            end else begin
                nt = evQ.pop_front();
                check("event kind", {4'h0, nt.code}, {4'h0, ev});
                check("event cycle", 8'h1, {7'h0, cyc >= nt.lo &&
                    cyc <= nt.hi});
            end
            if (vectorCall === 1'b1) begin
                check("intVector", VECTOR_ADDR, intVector);
            end
        end
    end

    initial begin
        mclk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
    end
    initial begin
        #600000;
        bad_count++;
        $display("FAIL watchdog expected end seen hang");
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        seed = 32'hd5071385;
        {reset, regWrite, regRead, rdPend, keepAlive, stackFull} = 6'h20;
        {regAddr, cmd, regWrData, cyc, lastCyc} = 0;
        {externalResetPin_n, wdtOscTick, rtcTick, portA} = 11'h7FF;
        {bad_count, cmp_count} = 0;
        {clrFirst, clrSecond} = 2'h0;
        ticks(6);
        reset <= 1'b0;
        ticks(1);
        for (i = 0; i < 4; i++) rd(i[1:0], 8'h0);
        wr(OFS_STATUS, 8'hFF);
        rd(OFS_STATUS, 8'h0);
        keepAlive <= 1'b1;
        $display("test reset values done");
        wr(OFS_INTERRUPT_CONTROL_ONE, 8'h01);
        for (i = 0; i < 5; i++) begin
            per = (i < 4) ? (256 << i) : 4096;
            wr(OFS_MULTIFUNCTION_INT_CONTROL, (i < 4) ? 8'h02 : 8'h01);
            wr(OFS_TICK_CONTROL_REGISTER, i[7:0]);
            note(4'h4, cyc, cyc + per + 8);
            settle(per + 10);
            wr(OFS_MULTIFUNCTION_INT_CONTROL, (i < 4) ? 8'h02 : 8'h01);
            note(4'h4, lastCyc + per, lastCyc + per);
            settle(per + 10);
            if (i == 0) begin
                rd(OFS_MULTIFUNCTION_INT_CONTROL, 8'h0A);
                rd(OFS_INTERRUPT_CONTROL_ONE, 8'h01);
            end
            $display("test period %0d done", per);
        end
        wr(OFS_TICK_CONTROL_REGISTER, 8'h00);
        wr(OFS_INTERRUPT_CONTROL_ONE, 8'h02);
        wr(OFS_MULTIFUNCTION_INT_CONTROL, 8'h0C);
        for (src = 0; src < 4; src++) begin
            if (src >= 2) begin
                wr(OFS_MULTIFUNCTION_INT_CONTROL, 8'h0A);
                wr(OFS_INTERRUPT_CONTROL_ONE, 8'h01);
                note(4'h4, cyc, cyc + 300);
                settle(300);
                wr(OFS_MULTIFUNCTION_INT_CONTROL, 8'h02);
                stackFull <= (src == 3);
            end
            halt();
            if (src == 0) begin
                pin = {$random(seed)} % 7;
                portA <= 8'h7F;
                ticks(1100);
                portA <= 8'hFF;
                ticks(2);
                portA <= ~(8'h1 << pin);
                note(4'h8, cyc + 1024, cyc + 1030);
            end else if (src == 1) begin
                externalResetPin_n <= 1'b0;
                ticks(2);
                externalResetPin_n <= 1'b1;
                note(4'h8, cyc + 1022, cyc + 1030);
            end else if (src == 2) begin
                note(4'h4, cyc + 1028, cyc + 1300);
            end else begin
                note(4'h8, cyc + 1024, cyc + 1290);
            end
            settle(1400);
            portA <= 8'hFF;
            if (src == 3) begin
                stackFull <= 1'b0;
                note(4'h4, cyc, cyc + 6);
                settle(10);
            end
            if (src < 2) begin
                pulse_pair(!src[0], src[0]);
                pulse_pair(!src[0], src[0]);
                check("pair powerdownFlag", 8'h1, pairPd);
                pulse_pair(src[0], !src[0]);
                check("pair powerdownFlag", 8'h0, pairPd);
            end
            check("sysOscRun", 8'h1, sysOscRun);
            instr(2'h2);
            check("powerdownFlag", 8'h0, powerdownFlag);
            keepAlive <= 1'b1;
            $display("test wake source %0d done", src);
        end
        wr(OFS_INTERRUPT_CONTROL_ONE, 8'h02);
        wr(OFS_MULTIFUNCTION_INT_CONTROL, 8'h0C);
        halt();
        note(4'h2, cyc + 4000, cyc + 9230);
        settle(9300);
        ticks(2);
        check("timeoutFlag", 8'h1, timeoutFlag);
        check("powerdownFlag", 8'h1, powerdownFlag);
        instr(2'h2);
        note(4'h1, cyc, cyc + 8200);
        settle(8300);
        ticks(2);
        rd(OFS_STATUS, 8'h01);
        ticks(3);
        $display("test watchdog time-out done");
        print_verdict();
    end
endmodule
`default_nettype wire
